// *** design/dual_bitstream_modulator.sv ***
`timescale 1ns/1ps
`default_nettype none
module dual_bitstream_modulator (
  input wire logic clk,
  input wire logic rst,
  input wire logic clock_source_select,
  input wire logic signed [modulator_pkg::INPUT_W-1:0] first_channel_input,
  input wire logic signed [modulator_pkg::INPUT_W-1:0] second_channel_input,
  modulator_link_if.device link
);
  import modulator_pkg::*;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [1:0] sel_sync_reg, sel_sync_next;
  logic [2:0] ext_sync_reg, ext_sync_next;
  always_comb begin
    sel_sync_next = {sel_sync_reg[0], clock_source_select};
    ext_sync_next = {ext_sync_reg[1:0], link.external_clock_in};
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_sync_reg <= 2'h3;
      ext_sync_reg <= 3'h0;
    end else begin
      sel_sync_reg <= sel_sync_next;
      ext_sync_reg <= ext_sync_next;
    end
  end

  // ----------------------------------------
  // Device clock source
  // ----------------------------------------
  // Internal oscillator emulated by divider; one pulse per device clock
  // First pulse a full period after reset, so the select synchroniser
  // settles first and external mode sees no stray bit clock edge
  logic [7:0] osc_cnt_reg, osc_cnt_next;
  logic dev_tick;
  always_comb begin
    osc_cnt_next = osc_cnt_reg + 8'h01;
    if (osc_cnt_reg == 8'(2 * INT_OSC_DIV - 1)) begin
      osc_cnt_next = 8'h00;
    end
    if (sel_sync_reg[1]) begin
      dev_tick = (osc_cnt_reg == 8'(2 * INT_OSC_DIV - 1));
    end else begin
      dev_tick = ext_sync_reg[1] & ~ext_sync_reg[2];
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      osc_cnt_reg <= 8'h00;
    end else begin
      osc_cnt_reg <= osc_cnt_next;
    end
  end

  // ----------------------------------------
  // Bit clock and modulators
  // ----------------------------------------
  logic bclk_reg, bclk_next;
  logic mod_tick;
  logic first_bit_reg, first_bit_next, second_bit_reg, second_bit_next;
  logic first_out_reg, first_out_next, second_out_reg, second_out_next;
  logic signed [ACC_W-1:0] i1a_reg, i1a_next, i2a_reg, i2a_next;
  logic signed [ACC_W-1:0] i1b_reg, i1b_next, i2b_reg, i2b_next;
  logic signed [ACC_W-1:0] fb_a, fb_b, xa, xb;
  always_comb begin
    // Halving: toggle per device tick, rise marks a modulator clock
    bclk_next = dev_tick ? ~bclk_reg : bclk_reg;
    mod_tick = dev_tick & ~bclk_reg;
    // Input scaled so full scale maps to 92%/8% density
    xa = ACC_W'((32'(signed'(first_channel_input)) * int'(DENSITY_SPAN)) / 100);
    xb = ACC_W'((32'(signed'(second_channel_input)) * int'(DENSITY_SPAN)) / 100);
    fb_a = first_bit_reg ? ACC_W'(FULL_SCALE) : ACC_W'(NEG_FULL_SCALE);
    fb_b = second_bit_reg ? ACC_W'(FULL_SCALE) : ACC_W'(NEG_FULL_SCALE);
    i1a_next = i1a_reg;
    i2a_next = i2a_reg;
    i1b_next = i1b_reg;
    i2b_next = i2b_reg;
    first_bit_next = first_bit_reg;
    second_bit_next = second_bit_reg;
    // Pins follow the loop bits one clock late: hold time after the rise
    first_out_next = first_bit_reg;
    second_out_next = second_bit_reg;
    if (mod_tick) begin
      // Second-order loop; bit taken only at modulator clock, one per clock
      i1a_next = i1a_reg + xa - fb_a;
      i2a_next = i2a_reg + i1a_next - fb_a;
      i1b_next = i1b_reg + xb - fb_b;
      i2b_next = i2b_reg + i1b_next - fb_b;
      first_bit_next = ~i2a_next[ACC_W-1];
      second_bit_next = ~i2b_next[ACC_W-1];
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bclk_reg <= 1'b0;
      i1a_reg <= '0;
      i2a_reg <= '0;
      i1b_reg <= '0;
      i2b_reg <= '0;
      first_bit_reg <= 1'b0;
      second_bit_reg <= 1'b0;
      first_out_reg <= 1'b0;
      second_out_reg <= 1'b0;
    end else begin
      bclk_reg <= bclk_next;
      i1a_reg <= i1a_next;
      i2a_reg <= i2a_next;
      i1b_reg <= i1b_next;
      i2b_reg <= i2b_next;
      first_bit_reg <= first_bit_next;
      second_bit_reg <= second_bit_next;
      first_out_reg <= first_out_next;
      second_out_reg <= second_out_next;
    end
  end

  // Bits change one clock after the bit clock rise, so a receiver
  // sampling on that rise still sees the old bit
  assign link.bit_clock_out = bclk_reg;
  assign link.first_channel_bitstream = first_out_reg;
  assign link.second_channel_bitstream = second_out_reg;
endmodule
`default_nettype wire

// *** design/modulator_pkg.sv ***
`default_nettype none
package modulator_pkg;
  localparam int unsigned CLK_HZ = 200000000;
  localparam int unsigned INT_OSC_HZ = 20000000;
  localparam int unsigned INT_OSC_DIV = CLK_HZ / (2 * INT_OSC_HZ);
  localparam int unsigned EXT_MIN_HZ = 1000000;
  localparam int unsigned EXT_MAX_HZ = 24000000;
  localparam int unsigned INPUT_W = 16;
  localparam int unsigned ACC_W = 20;
  localparam logic signed [INPUT_W-1:0] FULL_SCALE = 16'sh7FFF;
  localparam logic signed [INPUT_W-1:0] NEG_FULL_SCALE = -16'sh7FFF;
  localparam int unsigned DENSITY_SPAN = 84;
  localparam int unsigned DENSITY_CENTER = 50;
  localparam int unsigned OSR_DEFAULT = 64;
  localparam int unsigned WORD_W = 24;
endpackage
`default_nettype wire

// *** design/modulator_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface modulator_link_if;
  logic external_clock_in;
  logic bit_clock_out;
  logic first_channel_bitstream;
  logic second_channel_bitstream;
  modport device (input external_clock_in, output bit_clock_out,
    output first_channel_bitstream, output second_channel_bitstream);
  modport receiver (output external_clock_in, input bit_clock_out,
    input first_channel_bitstream, input second_channel_bitstream);
endinterface
`default_nettype wire

// *** design/sinc_receiver.sv ***
`timescale 1ns/1ps
`default_nettype none
module sinc_receiver #(
  parameter int unsigned OVERSAMPLING_RATIO = modulator_pkg::OSR_DEFAULT,
  parameter int unsigned EXT_DIV = 5
) (
  input wire logic clk,
  input wire logic rst,
  output logic [modulator_pkg::WORD_W-1:0] first_word,
  output logic [modulator_pkg::WORD_W-1:0] second_word,
  output logic word_valid,
  modulator_link_if.receiver link
);
  import modulator_pkg::*;

  if (OVERSAMPLING_RATIO < 2 || OVERSAMPLING_RATIO > 256 || EXT_DIV < 5 || EXT_DIV > 100) begin : g_bad_param
    $error("sinc_receiver: unsupported OVERSAMPLING_RATIO or EXT_DIV");
  end

  // ----------------------------------------
  // External clock generation
  // ----------------------------------------
  // EXT_DIV 5..100 keeps the clock inside 1MHz..24MHz at 200MHz
  logic [7:0] div_reg, div_next;
  logic xclk_reg, xclk_next;
  always_comb begin
    div_next = (div_reg == 8'(EXT_DIV - 1)) ? 8'h00 : div_reg + 8'h01;
    xclk_next = (div_reg == 8'(EXT_DIV - 1)) ? ~xclk_reg : xclk_reg;
  end

  // ----------------------------------------
  // Capture and sinc3 decimation
  // ----------------------------------------
  logic [2:0] bclk_sync_reg, bclk_sync_next;
  logic [1:0] fa_sync_reg, fa_sync_next, fb_sync_reg, fb_sync_next;
  logic [WORD_W-1:0] acc_a_reg[3], acc_a_next[3], acc_b_reg[3], acc_b_next[3];
  logic [WORD_W-1:0] dif_a_reg[3], dif_a_next[3], dif_b_reg[3], dif_b_next[3];
  logic [WORD_W-1:0] wa_reg, wa_next, wb_reg, wb_next, ca, cb;
  logic [8:0] cnt_reg, cnt_next;
  logic vld_reg, vld_next, rise;
  always_comb begin
    bclk_sync_next = {bclk_sync_reg[1:0], link.bit_clock_out};
    // Same lag as the bit clock; the device holds one clock, so the
    // pre-edge value is the one taken
    fa_sync_next = {fa_sync_reg[0], link.first_channel_bitstream};
    fb_sync_next = {fb_sync_reg[0], link.second_channel_bitstream};
    rise = bclk_sync_reg[1] & ~bclk_sync_reg[2];
    acc_a_next = acc_a_reg;
    acc_b_next = acc_b_reg;
    dif_a_next = dif_a_reg;
    dif_b_next = dif_b_reg;
    wa_next = wa_reg;
    wb_next = wb_reg;
    cnt_next = cnt_reg;
    vld_next = 1'b0;
    ca = '0;
    cb = '0;
    if (rise) begin
      acc_a_next[0] = acc_a_reg[0] + WORD_W'(fa_sync_reg[1]);
      acc_b_next[0] = acc_b_reg[0] + WORD_W'(fb_sync_reg[1]);
      for (int i = 1; i < 3; i++) begin
        acc_a_next[i] = acc_a_reg[i] + acc_a_reg[i-1];
        acc_b_next[i] = acc_b_reg[i] + acc_b_reg[i-1];
      end
      cnt_next = (cnt_reg == 9'(OVERSAMPLING_RATIO - 1)) ? 9'h000 : cnt_reg + 9'h001;
      if (cnt_reg == 9'(OVERSAMPLING_RATIO - 1)) begin
        // Comb section at 1/OVERSAMPLING_RATIO of the bit rate
        ca = acc_a_reg[2];
        cb = acc_b_reg[2];
        for (int i = 0; i < 3; i++) begin
          dif_a_next[i] = ca;
          dif_b_next[i] = cb;
          ca = ca - dif_a_reg[i];
          cb = cb - dif_b_reg[i];
        end
        wa_next = ca;
        wb_next = cb;
        vld_next = 1'b1;
      end
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_reg <= 8'h00;
      xclk_reg <= 1'b0;
      bclk_sync_reg <= 3'h0;
      fa_sync_reg <= 2'h0;
      fb_sync_reg <= 2'h0;
      acc_a_reg <= '{default: '0};
      acc_b_reg <= '{default: '0};
      dif_a_reg <= '{default: '0};
      dif_b_reg <= '{default: '0};
      wa_reg <= '0;
      wb_reg <= '0;
      cnt_reg <= 9'h000;
      vld_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      xclk_reg <= xclk_next;
      bclk_sync_reg <= bclk_sync_next;
      fa_sync_reg <= fa_sync_next;
      fb_sync_reg <= fb_sync_next;
      acc_a_reg <= acc_a_next;
      acc_b_reg <= acc_b_next;
      dif_a_reg <= dif_a_next;
      dif_b_reg <= dif_b_next;
      wa_reg <= wa_next;
      wb_reg <= wb_next;
      cnt_reg <= cnt_next;
      vld_reg <= vld_next;
    end
  end
  assign link.external_clock_in = xclk_reg;
  assign first_word = wa_reg;
  assign second_word = wb_reg;
  assign word_valid = vld_reg;
endmodule
`default_nettype wire

// *** verif/modulator_link_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module modulator_link_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic clock_source_select,
  input wire logic external_clock_in,
  input wire logic bit_clock_out,
  input wire logic first_channel_bitstream,
  input wire logic second_channel_bitstream
);
  wire sel = clock_source_select;
  wire ext = external_clock_in;
  wire bc = bit_clock_out;
  wire fa = first_channel_bitstream;
  wire fb = second_channel_bitstream;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------
  // Bit clock timing
  // ----------------
  sequence s_hold9;
    $stable(bc)[*8] ##1 $stable(bc);
  endsequence
  property p_int_half;
    sel && $changed(bc) |=> s_hold9 ##1 $changed(bc);
  endproperty
  a_int_half: assert property (p_int_half) else $error("internal half period");
  property p_int_period;
    sel && $rose(bc) |-> ##20 $rose(bc);
  endproperty
  a_int_period: assert property (p_int_period) else $error("internal period");
  property p_ext_lat;
    !sel && $rose(ext) |-> ##[2:4] $changed(bc);
  endproperty
  a_ext_lat: assert property (p_ext_lat) else $error("external edge lost");
  property p_ext_half;
    !sel && $changed(bc) |=> s_hold9;
  endproperty
  a_ext_half: assert property (p_ext_half) else $error("external half period");
  property p_ext_clk;
    $changed(ext) |=> $stable(ext)[*4] ##1 $changed(ext);
  endproperty
  a_ext_clk: assert property (p_ext_clk) else $error("external clock rate");
  // ----------------
  // Data and reset
  // ----------------
  property p_rise_a;
    $changed(fa) |-> bc && $past(bc) && !$past(bc, 2);
  endproperty
  a_rise_a: assert property (p_rise_a) else $error("first stream off edge");
  property p_rise_b;
    $changed(fb) |-> bc && $past(bc) && !$past(bc, 2);
  endproperty
  a_rise_b: assert property (p_rise_b) else $error("second stream off edge");
  property p_reset;
    $fell(rst) |-> !bc && !fa && !fb && !ext;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs not cleared");
endmodule
`default_nettype wire

// *** verif/test_dual_bitstream_modulator_clocking.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin n_compared++; if ((e) !== (s)) begin n_mismatch++; \
  $display("[ERR] %s expected %0h seen %0h", nm, e, s); end end
module test_dual_bitstream_modulator_clocking;
  import modulator_pkg::*;
  logic clk = 0;
  logic rst = 1;
  logic sel = 1;
  logic signed [INPUT_W-1:0] in_a = '0;
  logic signed [INPUT_W-1:0] in_b = '0;
  logic [WORD_W-1:0] word_a;
  logic [WORD_W-1:0] word_b;
  logic valid;
  logic bc_q = 0;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  int rises = 0;
  int win = 0;
  int seed = 32'hC03D9C21;
  modulator_link_if link ();
  dual_bitstream_modulator dual_bitstream_modulator_inst (.clk(clk), .rst(rst),
    .clock_source_select(sel), .first_channel_input(in_a),
    .second_channel_input(in_b), .link(link));
  sinc_receiver sinc_receiver_inst (.clk(clk), .rst(rst), .first_word(word_a),
    .second_word(word_b), .word_valid(valid), .link(link));
  modulator_link_props modulator_link_props_inst (.clk(clk), .rst(rst),
    .clock_source_select(sel), .external_clock_in(link.external_clock_in),
    .bit_clock_out(link.bit_clock_out), .first_channel_bitstream(link.first_channel_bitstream),
    .second_channel_bitstream(link.second_channel_bitstream));
  always #2.5 clk = ~clk;
  // ----------------
  // Rise count per word, timeout
  // ----------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    bc_q <= link.bit_clock_out;
    rises <= valid ? int'(link.bit_clock_out & ~bc_q) : rises + int'(link.bit_clock_out & ~bc_q);
    if (valid) begin
      win <= rises;
    end
    if (cyc == 60000) begin
      n_mismatch++;
      close_out();
    end
  end
  // Two percent window absorbs sinc3 ripple of the modulator noise
  function automatic logic near(input logic [WORD_W-1:0] w, input int x);
    longint e;
    e = longint'(OSR_DEFAULT ** 3) * (50 * 32767 + 42 * x) / 3276700;
    return (longint'(w) > e - 5243) && (longint'(w) < e + 5243);
  endfunction
  task automatic wait_word;
    do begin
      @(posedge clk);
      #1;
    end while (valid !== 1'b1);
  endtask
  // Four words so the sinc3 span holds only the new input
  task automatic run(input int a, input int b);
    in_a = a[INPUT_W-1:0];
    in_b = b[INPUT_W-1:0];
    repeat (4) wait_word();
    `CHK("bits_per_word", OSR_DEFAULT, win)
    `CHK("first_word", 1'b1, near(word_a, a))
    `CHK("second_word", 1'b1, near(word_b, b))
    $display("test done sel=%0d a=%0d b=%0d", sel, a, b);
  endtask
  task automatic close_out;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    #1 rst = 0;
    run(0, 32767);
    run(-32767, 0);
    repeat (2) run($random(seed) % 32767, $random(seed) % 32767);
    @(posedge clk);
    #1 rst = 1;
    sel = 0;
    repeat (4) @(posedge clk);
    #1 rst = 0;
    run(32767, -32767);
    run($random(seed) % 32767, $random(seed) % 32767);
    close_out();
  end
endmodule
`default_nettype wire
